//--- logic/ubp_map.svh
`ifndef UBP_MAP_SVH
`define UBP_MAP_SVH
// baud divider layout
`define UBP_FRAC_W 4
`define UBP_DIV_W 16
`define UBP_OVERSAMPLE 16
// frame field values
`define UBP_START_BIT 1'b0
`define UBP_STOP_BIT 1'b1
`define UBP_IDLE_LEVEL 1'b1
`define UBP_DATA_W 9
`define UBP_BITS_SHORT 4'h8
`define UBP_BITS_LONG 4'h9
`define UBP_LAST_TICK 4'hF
`define UBP_MID_TICK 4'h7
`endif

//--- logic/ubp_pkg.sv
package ubp_pkg;
  // serial engine states
  typedef enum logic [1:0] {
    UBP_IDLE  = 2'b00,
    UBP_START = 2'b01,
    UBP_DATA  = 2'b10,
    UBP_STOP  = 2'b11
  } ubp_state_t;
endpackage : ubp_pkg

//--- logic/ubp_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubp_map.svh"
// ----------------------------------------
// fractional baud tick generator
// ----------------------------------------
module ubp_baud_gen #(
  parameter int DIV_W = `UBP_DIV_W,
  parameter int FRAC_W = `UBP_FRAC_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset
  input wire logic [DIV_W-1:0] divider_value, // fixed-point divider
  input wire logic div_load, // divider written
  output logic tick // one 16x oversample tick
);
  // refuse a divider with no whole part left above the fraction
  if (DIV_W <= FRAC_W) begin : g_bad_width
    $error("divider too narrow");
  end
  // accumulator counts sixteenths of a clock against divider
  logic [DIV_W:0] acc_q;
  logic [DIV_W:0] sum;
  always_comb begin
    sum = acc_q + (DIV_W+1)'(1 << FRAC_W);
  end
  // one tick when accumulated clocks reach the divider; remainder kept
  always_ff @(posedge clk_sys) begin
    if (rst || div_load) begin
      acc_q <= '0;
      tick <= 1'b0;
    end else if (divider_value == '0) begin
      acc_q <= '0;
      tick <= 1'b0;
    end else if (divider_value < (DIV_W)'(1 << FRAC_W)) begin
      // below one clock per tick: tick every clock, keep no remainder
      // so the accumulator cannot creep up and wrap
      acc_q <= '0;
      tick <= 1'b1;
    end else if (sum >= {1'b0, divider_value}) begin
      acc_q <= sum - {1'b0, divider_value};
      tick <= 1'b1;
    end else begin
      acc_q <= sum;
      tick <= 1'b0;
    end
  end
endmodule : ubp_baud_gen
`default_nettype wire

//--- logic/ubp_uart_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubp_map.svh"
// ----------------------------------------
// baud, parity and transmit dma slice
// ----------------------------------------
// Summary of operation
// - bit rate is clock over sixteen divider
// - divider low four bits are sixteenths
// - divider write reloads baud counter immediately
// - one divider shared by transmit, receive
// - parity enable inserts and checks parity
// - frame size from word length only; parity takes the last body bit
// - select zero gives even parity
// - select one gives odd parity
// - receive parity mismatch sets error flag
// - parity error with enable raises irq
// - dma request while transmit empty, enabled
// - data sent least significant bit first
module ubp_uart_core (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset
  input wire logic [`UBP_DIV_W-1:0] baud_divider_reg, // divider write data
  input wire logic div_wr, // divider write strobe
  input wire logic parity_enable, // parity on
  input wire logic parity_select, // 0 even, 1 odd
  input wire logic word_length_select, // 0 short, 1 long word
  input wire logic parity_error_irq_enable, // parity irq enable
  input wire logic tx_dma_enable, // transmit dma enable
  input wire logic [`UBP_DATA_W-1:0] data_reg, // transmit word
  input wire logic data_wr, // transmit word write
  input wire logic rx_data_rd, // receive word read, clears flags
  input wire logic rxd, // serial input
  output logic txd, // serial output
  output logic tx_empty_flag, // transmit holding empty
  output logic tx_dma_req, // transmit dma request
  output logic [`UBP_DATA_W-1:0] rx_data, // received word
  output logic rx_not_empty_flag, // received word ready
  output logic parity_error_flag, // parity mismatch
  output logic irq // interrupt request
);
  logic [`UBP_DIV_W-1:0] divider_value; // active divider
  logic tick; // shared oversample tick

  // ----------------------------------------
  // divider and tick
  // ----------------------------------------
  // the written value lands at once; no staging register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divider_value <= '0;
    end else if (div_wr) begin
      divider_value <= baud_divider_reg;
    end
  end

  // one generator feeds both directions
  ubp_baud_gen #(
    .DIV_W(`UBP_DIV_W),
    .FRAC_W(`UBP_FRAC_W)
  ) u_baud (
    .clk_sys(clk_sys),
    .rst(rst),
    .divider_value(divider_value),
    .div_load(div_wr),
    .tick(tick)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bits per frame body (data plus parity)
  function automatic logic [3:0] body_bits(input logic wl);
    body_bits = wl ? `UBP_BITS_LONG : `UBP_BITS_SHORT;
  endfunction : body_bits

  // parity over the live data bits, odd adds one
  function automatic logic par_of(input logic [`UBP_DATA_W-1:0] d,
                                  input logic wl, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < `UBP_DATA_W; i++) begin
      if (4'(i) < body_bits(wl) - 4'h1) p = p ^ d[i];
    end
    par_of = p;
  endfunction : par_of

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  ubp_pkg::ubp_state_t tx_st_q;
  logic [`UBP_DATA_W-1:0] tx_hold_q; // holding word
  logic [`UBP_DATA_W-1:0] tx_sh_q; // shift word
  logic [3:0] tx_tk_q; // oversample count
  logic [3:0] tx_bit_q; // bit index
  logic tx_full_q; // holding occupied

  // holding register handshake
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_full_q <= 1'b0;
      tx_hold_q <= '0;
    end else if (data_wr) begin
      tx_full_q <= 1'b1;
      tx_hold_q <= data_reg;
    end else if (tx_st_q == ubp_pkg::UBP_IDLE && tx_full_q) begin
      tx_full_q <= 1'b0;
    end
  end

  assign tx_empty_flag = ~tx_full_q;
  assign tx_dma_req = tx_dma_enable & tx_empty_flag;

  // frame sequencer, sixteen ticks per bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q <= ubp_pkg::UBP_IDLE;
      tx_sh_q <= '0;
      tx_tk_q <= '0;
      tx_bit_q <= '0;
      txd <= `UBP_IDLE_LEVEL;
    end else if (tx_st_q == ubp_pkg::UBP_IDLE) begin
      txd <= `UBP_IDLE_LEVEL;
      if (tx_full_q && !data_wr) begin
        tx_sh_q <= tx_hold_q;
        if (parity_enable) begin
          // parity replaces last body bit
          tx_sh_q[body_bits(word_length_select) - 4'h1] <=
            par_of(tx_hold_q, word_length_select, parity_select);
        end
        tx_st_q <= ubp_pkg::UBP_START;
        tx_tk_q <= '0;
        txd <= `UBP_START_BIT;
      end
    end else if (tick) begin
      tx_tk_q <= tx_tk_q + 4'h1;
      if (tx_tk_q == `UBP_LAST_TICK) begin
        unique case (tx_st_q)
          ubp_pkg::UBP_START: begin
            tx_st_q <= ubp_pkg::UBP_DATA;
            tx_bit_q <= '0;
            txd <= tx_sh_q[0];
          end
          ubp_pkg::UBP_DATA: begin
            if (tx_bit_q == body_bits(word_length_select) - 4'h1) begin
              tx_st_q <= ubp_pkg::UBP_STOP;
              txd <= `UBP_STOP_BIT;
            end else begin
              tx_bit_q <= tx_bit_q + 4'h1;
              txd <= tx_sh_q[tx_bit_q + 4'h1];
            end
          end
          ubp_pkg::UBP_STOP: begin
            tx_st_q <= ubp_pkg::UBP_IDLE;
          end
          default: tx_st_q <= ubp_pkg::UBP_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // receiver (mid-bit sample only)
  // ----------------------------------------
  ubp_pkg::ubp_state_t rx_st_q;
  logic [`UBP_DATA_W-1:0] rx_sh_q; // incoming bits
  logic [3:0] rx_tk_q;
  logic [3:0] rx_bit_q;
  logic rx_perr; // parity check result

  always_comb begin
    rx_perr = parity_enable &&
      (par_of(rx_sh_q, word_length_select, parity_select) !=
       rx_sh_q[body_bits(word_length_select) - 4'h1]);
  end

  // frame capture; samples at the middle tick of each bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_q <= ubp_pkg::UBP_IDLE;
      rx_sh_q <= '0;
      rx_tk_q <= '0;
      rx_bit_q <= '0;
    end else if (rx_st_q == ubp_pkg::UBP_IDLE) begin
      if (rxd == `UBP_START_BIT) begin
        rx_st_q <= ubp_pkg::UBP_START;
        rx_tk_q <= '0;
        rx_sh_q <= '0;
      end
    end else if (tick) begin
      rx_tk_q <= rx_tk_q + 4'h1;
      if (rx_tk_q == `UBP_MID_TICK) begin
        unique case (rx_st_q)
          ubp_pkg::UBP_START: begin
            rx_st_q <= (rxd == `UBP_START_BIT) ? ubp_pkg::UBP_DATA
                                              : ubp_pkg::UBP_IDLE;
            rx_bit_q <= '0;
          end
          ubp_pkg::UBP_DATA: begin
            rx_sh_q[rx_bit_q] <= rxd;
            if (rx_bit_q == body_bits(word_length_select) - 4'h1)
              rx_st_q <= ubp_pkg::UBP_STOP;
            else
              rx_bit_q <= rx_bit_q + 4'h1;
          end
          ubp_pkg::UBP_STOP: rx_st_q <= ubp_pkg::UBP_IDLE;
          default: rx_st_q <= ubp_pkg::UBP_IDLE;
        endcase
      end
    end
  end

  logic rx_done; // stop bit sampled
  assign rx_done = tick && rx_tk_q == `UBP_MID_TICK &&
                   rx_st_q == ubp_pkg::UBP_STOP;

  // deliver word; parity slot masked out; set beats clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_data <= '0;
      rx_not_empty_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else if (rx_done) begin
      rx_not_empty_flag <= 1'b1;
      parity_error_flag <= rx_perr;
      rx_data <= rx_sh_q;
      if (parity_enable)
        rx_data[body_bits(word_length_select) - 4'h1] <= 1'b0;
      if (!word_length_select)
        rx_data[`UBP_DATA_W-1] <= 1'b0;
    end else if (rx_data_rd) begin
      rx_not_empty_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end
  end

  assign irq = parity_error_flag & parity_error_irq_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  dma_follows_empty_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_dma_enable && data_wr) |=> !tx_dma_req)
    else $error("dma request kept after word written");
  irq_follows_pe_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_done && rx_perr && parity_error_irq_enable) |=> irq)
    else $error("irq missing on parity error");
  perr_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_done && rx_perr) |=> parity_error_flag)
    else $error("parity error not flagged");
  no_perr_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_done && !parity_enable) |=> !parity_error_flag)
    else $error("parity error with parity off");
  div_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    div_wr |=> divider_value == $past(baud_divider_reg))
    else $error("divider not loaded");
  start_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_st_q == ubp_pkg::UBP_START) |-> !txd)
    else $error("start bit not low");
  stop_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_st_q == ubp_pkg::UBP_STOP) |-> txd)
    else $error("stop bit not high");
  lsb_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tx_st_q == ubp_pkg::UBP_START && tick && tx_tk_q == `UBP_LAST_TICK)
    |=> txd == $past(tx_sh_q[0]))
    else $error("first data bit not lsb");
  tick_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tick && divider_value >= 16'h0020 && !div_wr) |=> !tick)
    else $error("ticks too dense");
endmodule : ubp_uart_core
`default_nettype wire

//--- dv/ubp_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// remote transceiver and dma controller
// ----------------------------------------
module ubp_remote_model (
  input wire logic clk_sys, // system clock
  input wire logic txd, // line from the block
  input wire logic [7:0] bit_clk, // clocks per bit
  input wire logic wl, // long word frame
  input wire logic flip, // corrupt echoed last body bit
  input wire logic tx_dma_req, // dma request from block
  input wire logic dma_go, // start channel pulse
  input wire logic [8:0] dma_base, // first word of channel
  input wire logic [3:0] dma_len, // words to move
  output logic rxd, // line into the block
  output logic [8:0] data_reg, // word moved by dma
  output logic data_wr, // dma write strobe
  output logic got, // frame captured pulse
  output logic [8:0] cap, // captured frame body
  output logic dma_transfer_done_flag // channel finished
);
  logic [8:0] echo_q[$]; // frames waiting to go back
  logic [3:0] left = 4'h0; // words still to move
  logic [8:0] w; // capture shift word
  logic [8:0] e; // echo word
  int n; // body length
  // idle levels at time zero
  initial begin
    rxd = 1'b1;
    data_reg = 9'h000;
    data_wr = 1'b0;
    got = 1'b0;
    cap = 9'h000;
    dma_transfer_done_flag = 1'b0;
  end
  // channel moves one word per request, strobe lasts one cycle
  always @(negedge clk_sys) begin
    if (dma_go) begin
      left <= dma_len;
      data_reg <= dma_base;
      dma_transfer_done_flag <= 1'b0;
    end else if (data_wr) begin
      data_wr <= 1'b0;
      data_reg <= data_reg + 9'h001;
    end else if (left != 4'h0 && tx_dma_req) begin
      data_wr <= 1'b1;
      left <= left - 4'h1;
      dma_transfer_done_flag <= (left == 4'h1);
    end
  end
  // sample each bit in its middle, lsb first
  always begin
    @(negedge txd);
    repeat (bit_clk / 2) @(posedge clk_sys);
    n = wl ? 9 : 8;
    w = 9'h000;
    for (int i = 0; i < n; i++) begin
      repeat (bit_clk) @(posedge clk_sys);
      w[i] = txd;
    end
    repeat (bit_clk) @(posedge clk_sys);
    cap = w;
    echo_q.push_back(w ^ ({8'h00, flip} << (n - 1)));
    got = 1'b1;
    @(negedge clk_sys);
    got = 1'b0;
  end
  // send captured frames back, line idles high between them
  always begin
    wait (echo_q.size() != 0);
    e = echo_q.pop_front();
    @(negedge clk_sys);
    rxd = 1'b0;
    repeat (bit_clk) @(negedge clk_sys);
    for (int i = 0; i < (wl ? 9 : 8); i++) begin
      rxd = e[i];
      repeat (bit_clk) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (bit_clk) @(negedge clk_sys);
  end
endmodule : ubp_remote_model
`default_nettype wire

//--- dv/ubp_uart_core_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// frame, parity and dma regression
// ----------------------------------------
module ubp_uart_core_test;
  logic clk_sys = 1'b0, rst = 1'b1, div_wr = 1'b0; // clock, reset, load
  logic [15:0] baud_divider_reg = 16'h0000; // divider value
  logic parity_enable = 1'b0, parity_select = 1'b0; // parity mode
  logic word_length_select = 1'b0, parity_error_irq_enable = 1'b0;
  logic tx_dma_enable = 1'b0, rx_data_rd = 1'b0; // dma on, rx read
  logic [8:0] data_reg, rx_data, cap, dma_base = 9'h000; // words
  logic data_wr, rxd, txd, tx_empty_flag, tx_dma_req, got, done; // lines
  logic rx_not_empty_flag, parity_error_flag, irq; // status
  logic [7:0] bit_clk = 8'h20; // clocks per bit
  logic flip = 1'b0, dma_go = 1'b0; // echo fault, channel start
  logic [3:0] dma_len = 4'h0; // channel length
  logic [31:0] rng = 32'h21A0; // xorshift state
  logic [8:0] exp_tx[$]; // notes for captured frames
  logic [10:0] exp_rx[$]; // notes for received words
  int bad_count = 0, comparisons = 0; // tallies
  always #5 clk_sys = ~clk_sys;
  ubp_uart_core i_ubp_uart_core (.clk_sys(clk_sys), .rst(rst),
    .baud_divider_reg(baud_divider_reg), .div_wr(div_wr),
    .parity_enable(parity_enable), .parity_select(parity_select),
    .word_length_select(word_length_select),
    .parity_error_irq_enable(parity_error_irq_enable),
    .tx_dma_enable(tx_dma_enable), .data_reg(data_reg), .data_wr(data_wr),
    .rx_data_rd(rx_data_rd), .rxd(rxd), .txd(txd),
    .tx_empty_flag(tx_empty_flag), .tx_dma_req(tx_dma_req),
    .rx_data(rx_data), .rx_not_empty_flag(rx_not_empty_flag),
    .parity_error_flag(parity_error_flag), .irq(irq));
  ubp_remote_model i_ubp_remote_model (.clk_sys(clk_sys), .txd(txd),
    .bit_clk(bit_clk), .wl(word_length_select), .flip(flip),
    .tx_dma_req(tx_dma_req), .dma_go(dma_go), .dma_base(dma_base),
    .dma_len(dma_len), .rxd(rxd), .data_reg(data_reg), .data_wr(data_wr),
    .got(got), .cap(cap), .dma_transfer_done_flag(done));
  // compare and tally
  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // one frame format, two dma words, echoed back by the remote end
  task automatic run_mode(input logic [2:0] m, input logic [15:0] div);
    logic [8:0] d;
    logic p, fl;
    int n;
    fl = m[1] & (m[0] ^ m[2]);
    n = m[2] ? 9 : 8;
    rng = xs(rng);
    {word_length_select, parity_enable, parity_select} <= m;
    parity_error_irq_enable <= m[2];
    flip <= fl;
    bit_clk <= div[7:0]; // bit time equals divider in clocks
    baud_divider_reg <= div;
    div_wr <= 1'b1;
    dma_base <= rng[8:0];
    dma_len <= 4'h2;
    @(negedge clk_sys);
    div_wr <= 1'b0;
    dma_go <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      d = (rng[8:0] + i) & ((9'h001 << (n - m[1])) - 9'h001);
      p = ^d ^ m[0];
      exp_tx.push_back(m[1] ? d | ({8'h00, p} << (n - 1)) : d);
      exp_rx.push_back({m[2] & fl, fl, d});
    end
    @(negedge clk_sys);
    dma_go <= 1'b0;
    for (int k = 0; k < 5000 && exp_tx.size() + exp_rx.size() > 0; k++)
      @(negedge clk_sys);
    // a limit that runs out leaves notes behind and counts as a mismatch
    check(11'(exp_tx.size() + exp_rx.size()), 11'h000);
    check(done, 1'b1);
    $display("test mode %0d divider %h done", m, div);
  endtask : run_mode
  // frames seen by the remote end against the oldest note
  always @(posedge got) begin
    check(cap, exp_tx.pop_front());
  end
  // received words against the oldest note, then read out
  always @(posedge rx_not_empty_flag) begin
    @(negedge clk_sys);
    check({irq, parity_error_flag, rx_data}, exp_rx.pop_front());
    rx_data_rd <= 1'b1;
    @(negedge clk_sys);
    rx_data_rd <= 1'b0;
    check({rx_not_empty_flag, parity_error_flag, irq}, 11'h000);
  end
  // main sequence
  initial begin
    repeat (4) @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check({txd, tx_empty_flag, tx_dma_req}, 3'b110);
    tx_dma_enable <= 1'b1;
    @(negedge clk_sys);
    check(tx_dma_req, 1'b1);
    for (int m = 0; m < 8; m++) run_mode(m[2:0], 16'h0020);
    run_mode(3'b011, 16'h0018);
    give_verdict();
  end
  // hang guard
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
endmodule : ubp_uart_core_test
`default_nettype wire
